//--- design/out2_cfg_pkg.sv
// Constants, field layout and reset state for the OUT2 / DAC2 config slice.
// Assumes a byte-wide host control port on the device clock.
package out2_cfg_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_LEG_P_CONFIG = 8'h6C;
	localparam logic [7:0] ADDR_LEG_M_CONFIG = 8'h6D;
	localparam logic [7:0] ADDR_DAC2A_VOLUME = 8'h6E;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int DRIVE_MSB = 7;
	localparam int DRIVE_LSB = 6;
	localparam int LEVEL_MSB = 5;
	localparam int LEVEL_LSB = 3;
	localparam int BW_BIT = 0;
	localparam int FULLSCALE_BIT = 1;
	localparam int CM_TOL_BIT = 0;

	// Writable bits; the rest are reserved and read as zero
	localparam logic [7:0] MASK_LEG_P = 8'hF9;
	localparam logic [7:0] MASK_LEG_M = 8'hFB;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_LEG_CONFIG = 8'h20;
	localparam logic [7:0] RST_VOLUME = 8'hC9;
	localparam logic [1:0] RST_DRIVE = 2'h0;
	localparam logic [2:0] RST_LEVEL = 3'h4;
	localparam logic RST_BIT = 1'h0;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		DRIVE_LINE_OUT = 2'h0,
		DRIVE_HEADPHONE = 2'h1,
		DRIVE_FOUR_OHM = 2'h2,
		DRIVE_RECEIVER = 2'h3
	} drive_mode_e;

	localparam logic [2:0] LEVEL_MIN_LEGAL = 3'h4;
	localparam logic [4:0] ATTEN_LEVEL4 = 5'h08;
	localparam logic [4:0] ATTEN_LEVEL5 = 5'h0E;
	localparam logic [4:0] ATTEN_LEVEL6 = 5'h14;
	localparam logic [4:0] ATTEN_LEVEL7 = 5'h1A;
	localparam logic [4:0] ATTEN_ILLEGAL = 5'h00;

	localparam logic [7:0] VOL_MUTE = 8'h00;
	localparam logic [7:0] VOL_UNITY = 8'hC9;

	// ****************************************************************
	// Register bank state
	// ****************************************************************
	typedef struct packed {
		logic [1:0] p_drive;
		logic [2:0] p_level;
		logic bw;
		logic [1:0] m_drive;
		logic [2:0] m_level;
		logic fullscale;
		logic cm_tol;
		logic [7:0] volume;
		logic [7:0] rdata;
		logic rvalid;
		logic reserved_wr;
		logic [3:0] p_onehot;
		logic [3:0] m_onehot;
		logic [4:0] p_atten;
		logic [4:0] m_atten;
		logic [1:0] level_bad;
		logic mute;
		logic unity;
		logic boost;
	} bank_state_s;

	localparam bank_state_s RST_STATE = '{
		p_drive: RST_DRIVE,
		p_level: RST_LEVEL,
		bw: RST_BIT,
		m_drive: RST_DRIVE,
		m_level: RST_LEVEL,
		fullscale: RST_BIT,
		cm_tol: RST_BIT,
		volume: RST_VOLUME,
		rdata: 8'h00,
		rvalid: 1'h0,
		reserved_wr: 1'h0,
		p_onehot: 4'h1,
		m_onehot: 4'h1,
		p_atten: ATTEN_LEVEL4,
		m_atten: ATTEN_LEVEL4,
		level_bad: 2'h0,
		mute: 1'h0,
		unity: 1'h1,
		boost: 1'h0
	};

endpackage : out2_cfg_pkg

//--- design/out2_cfg_if.sv
// Carries stored fields to the decoder and decoded controls back.
// Index 0 is the positive leg, index 1 the negative leg.
`timescale 1ns/1ps
interface out2_cfg_if;
	logic [1:0][1:0] drive;
	logic [1:0][2:0] level;
	logic [7:0] vol_code;
	logic [1:0][3:0] drive_onehot;
	logic [1:0][4:0] atten_db;
	logic [1:0] level_bad;
	logic vol_mute;
	logic vol_unity;
	logic vol_boost;

	modport regs (
		output drive, level, vol_code,
		input drive_onehot, atten_db, level_bad,
		input vol_mute, vol_unity, vol_boost
	);

	modport dec (
		input drive, level, vol_code,
		output drive_onehot, atten_db, level_bad,
		output vol_mute, vol_unity, vol_boost
	);
endinterface : out2_cfg_if

//--- design/out2_field_decode.sv
// Combinational decode of the stored leg and volume fields.
// Assumes the register bank registers every result it takes from here.
`timescale 1ns/1ps
module out2_field_decode (
	// Fields in, decoded controls out
	out2_cfg_if.dec cfg
);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	function automatic logic [4:0] level_to_atten(input logic [2:0] code);
		case (code)
			3'h4: level_to_atten = out2_cfg_pkg::ATTEN_LEVEL4;
			3'h5: level_to_atten = out2_cfg_pkg::ATTEN_LEVEL5;
			3'h6: level_to_atten = out2_cfg_pkg::ATTEN_LEVEL6;
			3'h7: level_to_atten = out2_cfg_pkg::ATTEN_LEVEL7;
			default: level_to_atten = out2_cfg_pkg::ATTEN_ILLEGAL;
		endcase
	endfunction : level_to_atten

	function automatic logic [3:0] drive_to_onehot(input logic [1:0] code);
		drive_to_onehot = 4'h1 << code;
	endfunction : drive_to_onehot

	// ****************************************************************
	// Per-leg decode
	// ****************************************************************
	for (genvar leg = 0; leg < 2; leg++) begin : g_leg
		assign cfg.drive_onehot[leg] = drive_to_onehot(cfg.drive[leg]);
		assign cfg.atten_db[leg] = level_to_atten(cfg.level[leg]);
		assign cfg.level_bad[leg] =
			cfg.level[leg] < out2_cfg_pkg::LEVEL_MIN_LEGAL;
	end

	// ****************************************************************
	// Volume decode
	// ****************************************************************
	// mute, unity and boost
	assign cfg.vol_mute = cfg.vol_code == out2_cfg_pkg::VOL_MUTE;
	assign cfg.vol_unity = cfg.vol_code == out2_cfg_pkg::VOL_UNITY;
	assign cfg.vol_boost = cfg.vol_code > out2_cfg_pkg::VOL_UNITY;

endmodule : out2_field_decode

//--- design/dac_out2_config_regs.sv
// Register slice for the second analog output and the DAC2 path:
// two leg configuration registers and the channel 2A volume register.
// Assumes the host control port is decoded on ref_clk_i upstream, so its
// strobes are synchronous and need no synchroniser here.
`timescale 1ns/1ps

// Behaviour
// - Positive drive field bits 7:6, reset 0: line, headphone, 4 ohm, receiver.
// - Positive level bits 5:3, reset 4; 4..7 give -8,-14,-20,-26 dB.
// - Register one bit 0: 0 audio 24 kHz, 1 wide 96 kHz; reset 0.
// - Negative drive field bits 7:6 of register two, same encoding, reset 0.
// - Negative level bits 5:3, reset 4; 4..7 as positive; 0..3 unused.
// - Register two bit 1: full-scale 10 Vrms (0) or 5 Vrms (1); reset 0.
// - Register two bit 0: AC common-mode tolerance (0) or rail-to-rail (1).
// - Reserved bits read zero, are read-only; software writes only zeros.
// - Volume code: 0 mute, 1 is -100 dB, 0.5 dB steps, reset 0xC9.
// - Register one decodes at 0x6C and resets to 0x20.
// - Register two decodes at 0x6D and resets to 0x20.
// - Volume register decodes at 0x6E, all eight bits read and write.
module dac_out2_config_regs (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Host control port
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	output logic [7:0] host_rdata_o,
	output logic host_rdata_valid_o,
	output logic reserved_write_o,
	// Positive leg
	output logic [1:0] pos_leg_drive_sel_o,
	output logic [2:0] pos_leg_level_sel_o,
	output logic [3:0] pos_leg_drive_onehot_o,
	output logic [4:0] pos_leg_atten_db_o,
	// Negative leg
	output logic [1:0] neg_leg_drive_sel_o,
	output logic [2:0] neg_leg_level_sel_o,
	output logic [3:0] neg_leg_drive_onehot_o,
	output logic [4:0] neg_leg_atten_db_o,
	// Level code faults, bit 0 positive, bit 1 negative
	output logic [1:0] level_code_fault_o,
	// DAC channel 2 path
	output logic dac2_bandwidth_sel_o,
	output logic dac2_fullscale_sel_o,
	output logic dac2_common_mode_tolerance_o,
	// Channel 2A volume
	output logic [7:0] dac2a_volume_code_o,
	output logic dac2a_mute_o,
	output logic dac2a_unity_o,
	output logic dac2a_boost_o
);

	// ****************************************************************
	// State and decoder
	// ****************************************************************
	out2_cfg_pkg::bank_state_s st;
	out2_cfg_pkg::bank_state_s next_st;

	out2_cfg_if cfg ();

	assign cfg.drive[0] = st.p_drive;
	assign cfg.drive[1] = st.m_drive;
	assign cfg.level[0] = st.p_level;
	assign cfg.level[1] = st.m_level;
	assign cfg.vol_code = st.volume;

	out2_field_decode u_decode (
		.cfg(cfg.dec)
	);

	// ****************************************************************
	// Read image of each register
	// ****************************************************************
	// reserved bits read zero
	function automatic logic [7:0] leg_p_image(
		input out2_cfg_pkg::bank_state_s s
	);
		logic [7:0] img;
		img = 8'h00;
		img[out2_cfg_pkg::DRIVE_MSB:out2_cfg_pkg::DRIVE_LSB] = s.p_drive;
		img[out2_cfg_pkg::LEVEL_MSB:out2_cfg_pkg::LEVEL_LSB] = s.p_level;
		img[out2_cfg_pkg::BW_BIT] = s.bw;
		leg_p_image = img;
	endfunction : leg_p_image

	function automatic logic [7:0] leg_m_image(
		input out2_cfg_pkg::bank_state_s s
	);
		logic [7:0] img;
		img = 8'h00;
		img[out2_cfg_pkg::DRIVE_MSB:out2_cfg_pkg::DRIVE_LSB] = s.m_drive;
		img[out2_cfg_pkg::LEVEL_MSB:out2_cfg_pkg::LEVEL_LSB] = s.m_level;
		img[out2_cfg_pkg::FULLSCALE_BIT] = s.fullscale;
		img[out2_cfg_pkg::CM_TOL_BIT] = s.cm_tol;
		leg_m_image = img;
	endfunction : leg_m_image

	function automatic logic [7:0] read_reg(
		input logic [7:0] addr,
		input out2_cfg_pkg::bank_state_s s
	);
		case (addr)
			out2_cfg_pkg::ADDR_LEG_P_CONFIG: read_reg = leg_p_image(s);
			out2_cfg_pkg::ADDR_LEG_M_CONFIG: read_reg = leg_m_image(s);
			out2_cfg_pkg::ADDR_DAC2A_VOLUME: read_reg = s.volume;
			default: read_reg = 8'h00;
		endcase
	endfunction : read_reg

	// Flags a write that puts a one into a reserved position
	function automatic logic reserved_hit(
		input logic [7:0] data,
		input logic [7:0] mask
	);
		reserved_hit = |(data & ~mask);
	endfunction : reserved_hit

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'h0;
		next_st.reserved_wr = 1'h0;

		if (host_wr_i) begin
			case (host_addr_i)
				out2_cfg_pkg::ADDR_LEG_P_CONFIG: begin
					next_st.p_drive = host_wdata_i[
						out2_cfg_pkg::DRIVE_MSB:out2_cfg_pkg::DRIVE_LSB];
					next_st.p_level = host_wdata_i[
						out2_cfg_pkg::LEVEL_MSB:out2_cfg_pkg::LEVEL_LSB];
					next_st.bw = host_wdata_i[out2_cfg_pkg::BW_BIT];
					next_st.reserved_wr = reserved_hit(host_wdata_i,
						out2_cfg_pkg::MASK_LEG_P);
				end
				out2_cfg_pkg::ADDR_LEG_M_CONFIG: begin
					next_st.m_drive = host_wdata_i[
						out2_cfg_pkg::DRIVE_MSB:out2_cfg_pkg::DRIVE_LSB];
					next_st.m_level = host_wdata_i[
						out2_cfg_pkg::LEVEL_MSB:out2_cfg_pkg::LEVEL_LSB];
					next_st.fullscale =
						host_wdata_i[out2_cfg_pkg::FULLSCALE_BIT];
					next_st.cm_tol = host_wdata_i[out2_cfg_pkg::CM_TOL_BIT];
					next_st.reserved_wr = reserved_hit(host_wdata_i,
						out2_cfg_pkg::MASK_LEG_M);
				end
				out2_cfg_pkg::ADDR_DAC2A_VOLUME: begin
					next_st.volume = host_wdata_i;
				end
				default: begin
					next_st.reserved_wr = 1'h0;
				end
			endcase
		end

		// Read sees the value before a write in the same cycle
		if (host_rd_i) begin
			next_st.rvalid = 1'h1;
			next_st.rdata = read_reg(host_addr_i, st);
		end

		// Decoded controls trail the fields by one clock so that every
		// output leaves a flip-flop; the analog side sees no glitches.
		next_st.p_onehot = cfg.drive_onehot[0];
		next_st.m_onehot = cfg.drive_onehot[1];
		next_st.p_atten = cfg.atten_db[0];
		next_st.m_atten = cfg.atten_db[1];
		next_st.level_bad = cfg.level_bad;
		next_st.mute = cfg.vol_mute;
		next_st.unity = cfg.vol_unity;
		next_st.boost = cfg.vol_boost;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			st <= out2_cfg_pkg::RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign host_rdata_o = st.rdata;
	assign host_rdata_valid_o = st.rvalid;
	assign reserved_write_o = st.reserved_wr;

	assign pos_leg_drive_sel_o = st.p_drive;
	assign pos_leg_level_sel_o = st.p_level;
	assign pos_leg_drive_onehot_o = st.p_onehot;
	assign pos_leg_atten_db_o = st.p_atten;

	assign neg_leg_drive_sel_o = st.m_drive;
	assign neg_leg_level_sel_o = st.m_level;
	assign neg_leg_drive_onehot_o = st.m_onehot;
	assign neg_leg_atten_db_o = st.m_atten;

	assign level_code_fault_o = st.level_bad;

	assign dac2_bandwidth_sel_o = st.bw;
	assign dac2_fullscale_sel_o = st.fullscale;
	assign dac2_common_mode_tolerance_o = st.cm_tol;

	assign dac2a_volume_code_o = st.volume;
	assign dac2a_mute_o = st.mute;
	assign dac2a_unity_o = st.unity;
	assign dac2a_boost_o = st.boost;

endmodule : dac_out2_config_regs

//--- tb/dac_out2_config_regs_checker.sv
// Assertions for the OUT2 / DAC2 register slice.
// Assumes a bind to the top module's ports; one clock, synchronous reset.
`timescale 1ns/1ps
module dac_out2_config_regs_checker (
	// Clock, reset and host port
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic host_rdata_valid_o,
	input wire logic reserved_write_o,
	// Leg fields and decodes
	input wire logic [1:0] pos_leg_drive_sel_o,
	input wire logic [2:0] pos_leg_level_sel_o,
	input wire logic [3:0] pos_leg_drive_onehot_o,
	input wire logic [4:0] pos_leg_atten_db_o,
	input wire logic [1:0] neg_leg_drive_sel_o,
	input wire logic [2:0] neg_leg_level_sel_o,
	input wire logic [3:0] neg_leg_drive_onehot_o,
	input wire logic [4:0] neg_leg_atten_db_o,
	input wire logic [1:0] level_code_fault_o,
	// DAC path and volume
	input wire logic dac2_bandwidth_sel_o,
	input wire logic dac2_fullscale_sel_o,
	input wire logic dac2_common_mode_tolerance_o,
	input wire logic [7:0] dac2a_volume_code_o,
	input wire logic dac2a_mute_o,
	input wire logic dac2a_unity_o,
	input wire logic dac2a_boost_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	// Codes below 4 map to zero so a stray code never looks legal
	function automatic logic [4:0] atten(input logic [2:0] l);
		case (l)
			3'h4: return 5'h08;
			3'h5: return 5'h0E;
			3'h6: return 5'h14;
			3'h7: return 5'h1A;
			default: return 5'h00;
		endcase
	endfunction : atten

	host_read_pulse_a: assert property (
		host_rd_i ##1 !host_rd_i |-> host_rdata_valid_o ##1 !host_rdata_valid_o)
		else $error("read answer pulse wrong");
	pos_leg_write_a: assert property (
		host_wr_i && host_addr_i == 8'h6C |=> {pos_leg_drive_sel_o,
		pos_leg_level_sel_o, 2'h0, dac2_bandwidth_sel_o} ==
		($past(host_wdata_i) & 8'hF9)) else $error("positive leg write lost");
	neg_leg_write_a: assert property (
		host_wr_i && host_addr_i == 8'h6D |=> {neg_leg_drive_sel_o,
		neg_leg_level_sel_o, 1'h0, dac2_fullscale_sel_o,
		dac2_common_mode_tolerance_o} == ($past(host_wdata_i) & 8'hFB))
		else $error("negative leg write lost");
	volume_write_a: assert property (
		host_wr_i && host_addr_i == 8'h6E |=>
		dac2a_volume_code_o == $past(host_wdata_i))
		else $error("volume write lost");
	fields_hold_a: assert property (
		!host_wr_i |=> $stable({pos_leg_drive_sel_o, pos_leg_level_sel_o,
		neg_leg_drive_sel_o, neg_leg_level_sel_o, dac2_bandwidth_sel_o,
		dac2_fullscale_sel_o, dac2_common_mode_tolerance_o,
		dac2a_volume_code_o})) else $error("field moved without write");
	reserved_flag_a: assert property (
		1'h1 |=> reserved_write_o == $past(host_wr_i &&
		(host_addr_i == 8'h6C && host_wdata_i[2:1] != 2'h0 ||
		host_addr_i == 8'h6D && host_wdata_i[2])))
		else $error("reserved write flag wrong");
	pos_decode_a: assert property (
		1'b1 |=> pos_leg_drive_onehot_o == 4'h1 << $past(pos_leg_drive_sel_o)
		&& pos_leg_atten_db_o == atten($past(pos_leg_level_sel_o)) &&
		level_code_fault_o[0] == ($past(pos_leg_level_sel_o) < 3'h4))
		else $error("positive leg decode wrong");
	neg_decode_a: assert property (
		1'b1 |=> neg_leg_drive_onehot_o == 4'h1 << $past(neg_leg_drive_sel_o)
		&& neg_leg_atten_db_o == atten($past(neg_leg_level_sel_o)) &&
		level_code_fault_o[1] == ($past(neg_leg_level_sel_o) < 3'h4))
		else $error("negative leg decode wrong");
	volume_decode_a: assert property (
		1'b1 |=> {dac2a_mute_o, dac2a_unity_o, dac2a_boost_o} ==
		{$past(dac2a_volume_code_o) == 8'h00, $past(dac2a_volume_code_o) ==
		8'hC9, $past(dac2a_volume_code_o) > 8'hC9})
		else $error("volume decode wrong");
endmodule : dac_out2_config_regs_checker

//--- tb/dac_out2_config_regs_tb.sv
// Self-checking bench for the OUT2 / DAC2 register slice.
// Assumes the slice alone, host port driven on falling clock edges.
`timescale 1ns/1ps
module dac_out2_config_regs_tb;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] host_addr_i = 8'h00;
	logic [7:0] host_wdata_i = 8'h00;
	logic host_wr_i = 1'b0;
	logic host_rd_i = 1'b0;
	logic [7:0] host_rdata_o, dac2a_volume_code_o;
	logic host_rdata_valid_o, reserved_write_o, dac2_bandwidth_sel_o;
	logic dac2_fullscale_sel_o, dac2_common_mode_tolerance_o;
	logic dac2a_mute_o, dac2a_unity_o, dac2a_boost_o;
	logic [1:0] pos_leg_drive_sel_o, neg_leg_drive_sel_o, level_code_fault_o;
	logic [2:0] pos_leg_level_sel_o, neg_leg_level_sel_o;
	logic [3:0] pos_leg_drive_onehot_o, neg_leg_drive_onehot_o;
	logic [4:0] pos_leg_atten_db_o, neg_leg_atten_db_o;
	logic [7:0] vt [6] = '{8'h00, 8'h01, 8'hC8, 8'hC9, 8'hCA, 8'hFF};
	logic [7:0] ve [6] = '{8'h04, 8'h00, 8'h00, 8'h02, 8'h01, 8'h01};
	int miscompares = 0;
	int checks = 0;

	dac_out2_config_regs u_dac_out2_config_regs (.ref_clk_i, .resetn_i,
		.host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o,
		.host_rdata_valid_o, .reserved_write_o, .pos_leg_drive_sel_o,
		.pos_leg_level_sel_o, .pos_leg_drive_onehot_o, .pos_leg_atten_db_o,
		.neg_leg_drive_sel_o, .neg_leg_level_sel_o, .neg_leg_drive_onehot_o,
		.neg_leg_atten_db_o, .level_code_fault_o, .dac2_bandwidth_sel_o,
		.dac2_fullscale_sel_o, .dac2_common_mode_tolerance_o,
		.dac2a_volume_code_o, .dac2a_mute_o, .dac2a_unity_o, .dac2a_boost_o);

	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// ****************************************************************
	// Host port, check, reset and report tasks
	// ****************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Strobe drops a cycle after it rises, so back-to-back calls leave a gap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		host_addr_i = a;
		host_wdata_i = d;
		host_wr_i = 1'b1;
		@(negedge ref_clk_i);
		host_wr_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk_i);
		host_addr_i = a;
		host_rd_i = 1'b1;
		@(negedge ref_clk_i);
		host_rd_i = 1'b0;
		chk({7'h00, host_rdata_valid_o}, 8'h01);
		chk(host_rdata_o, e);
	endtask : rd

	task automatic do_reset;
		resetn_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		resetn_i = 1'b1;
	endtask : do_reset

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		do_reset();
		rd(8'h6C, 8'h20);
		rd(8'h6D, 8'h20);
		rd(8'h6E, 8'hC9);
		chk({pos_leg_drive_sel_o, pos_leg_level_sel_o, 3'h0}, 8'h20);
		chk({neg_leg_drive_sel_o, neg_leg_level_sel_o, 3'h0}, 8'h20);
		wr(8'h6C, 8'hFF);
		chk({7'h00, reserved_write_o}, 8'h01);
		rd(8'h6C, 8'hF9);
		wr(8'h6D, 8'hFF);
		rd(8'h6D, 8'hFB);
		chk({dac2_bandwidth_sel_o, dac2_fullscale_sel_o, 6'h00}, 8'hC0);
		wr(8'h6D, 8'h01);
		chk({7'h00, reserved_write_o}, 8'h00);
		chk({dac2_fullscale_sel_o, dac2_common_mode_tolerance_o}, 8'h01);
		wr(8'h6D, 8'h02);
		chk({dac2_fullscale_sel_o, dac2_common_mode_tolerance_o}, 8'h02);
		// Every drive code on both legs, levels in opposite order
		for (int i = 0; i < 4; i++) begin
			wr(8'h6C, {i[1:0], 3'(i + 4), 3'h0});
			wr(8'h6D, {~i[1:0], 3'(7 - i), 3'h0});
			@(negedge ref_clk_i);
			chk({pos_leg_drive_onehot_o, neg_leg_drive_onehot_o},
				{4'h1 << i, 4'h8 >> i});
			chk({1'b0, level_code_fault_o, pos_leg_atten_db_o},
				{3'h0, 5'(8 + 6 * i)});
			chk({3'h0, neg_leg_atten_db_o}, 8'(26 - 6 * i));
		end
		wr(8'h6C, 8'h18);
		wr(8'h6D, 8'h00);
		@(negedge ref_clk_i);
		chk({6'h00, level_code_fault_o}, 8'h03);
		rd(8'h6C, 8'h18);
		foreach (vt[k]) begin
			wr(8'h6E, vt[k]);
			chk(dac2a_volume_code_o, vt[k]);
			@(negedge ref_clk_i);
			chk({5'h00, dac2a_mute_o, dac2a_unity_o, dac2a_boost_o}, ve[k]);
			rd(8'h6E, vt[k]);
		end
		wr(8'h6F, 8'h55);
		rd(8'h6F, 8'h00);
		rd(8'h6B, 8'h00);
		rd(8'h6E, 8'hFF);
		// Read and write together: the read sees the old byte
		@(negedge ref_clk_i);
		host_addr_i = 8'h6E;
		host_wdata_i = 8'h3C;
		host_wr_i = 1'b1;
		host_rd_i = 1'b1;
		@(negedge ref_clk_i);
		host_wr_i = 1'b0;
		host_rd_i = 1'b0;
		chk(host_rdata_o, 8'hFF);
		rd(8'h6E, 8'h3C);
		do_reset();
		rd(8'h6E, 8'hC9);
		rd(8'h6C, 8'h20);
		report_and_stop();
	end

	// Tests need about a hundred cycles; this limit of 4000 is far beyond that
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule : dac_out2_config_regs_tb

bind dac_out2_config_regs dac_out2_config_regs_checker u_chk (.ref_clk_i,
	.resetn_i, .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i,
	.host_rdata_valid_o, .reserved_write_o, .pos_leg_drive_sel_o,
	.pos_leg_level_sel_o, .pos_leg_drive_onehot_o, .pos_leg_atten_db_o,
	.neg_leg_drive_sel_o, .neg_leg_level_sel_o, .neg_leg_drive_onehot_o,
	.neg_leg_atten_db_o, .level_code_fault_o, .dac2_bandwidth_sel_o,
	.dac2_fullscale_sel_o, .dac2_common_mode_tolerance_o,
	.dac2a_volume_code_o, .dac2a_mute_o, .dac2a_unity_o, .dac2a_boost_o);
